//--- inc/cmo_pkg.sv
// Purpose: Constants and types for the comparator one mode and interrupt-enable register
// Assumes: Byte-wide special function register access on the system clock
// Notes: Offsets, field positions and reset values live here only
package cmo_pkg;
    localparam logic [7:0] CMO_MODE_ADDR = 8'h9c;
    localparam logic [7:0] CMO_MODE_RESET = 8'h82;
    localparam int CMO_RSVD_BIT = 7;
    localparam int CMO_RISE_EN_BIT = 5;
    localparam int CMO_FALL_EN_BIT = 4;
    localparam int CMO_SPEED_LSB = 0;
    localparam logic CMO_RSVD_VALUE = 1'b1;
    localparam logic [1:0] CMO_SPEED_RESET = 2'h2;

    typedef enum logic [1:0] {
        CMO_SPEED_FASTEST = 2'b00,
        CMO_SPEED_MID_FAST = 2'b01,
        CMO_SPEED_MID_SLOW = 2'b10,
        CMO_SPEED_SLOWEST = 2'b11
    } cmo_speed_t;
endpackage

//--- inc/cmo_edge_if.sv
// Purpose: Carries comparator output and edge flag state between the register and flag logic
// Assumes: One clock domain
// Notes: Flag clears come from the riseFlagClear and fallFlagClear ports of the register block
`timescale 1ns/1ps
`default_nettype none
interface cmo_edge_if;
    logic compOut;
    logic riseClear;
    logic fallClear;
    logic riseFlag;
    logic fallFlag;
    modport flags (input compOut, input riseClear, input fallClear, output riseFlag, output fallFlag);
    modport user (output compOut, output riseClear, output fallClear, input riseFlag, input fallFlag);
endinterface
`default_nettype wire

//--- design/cmo_edge_flags.sv
// Purpose: Sticky rising and falling edge flags of comparator one
// Assumes: Comparator output already synchronous to core_clk
// Notes: A set in the same cycle as a clear wins
`timescale 1ns/1ps
`default_nettype none
module cmo_edge_flags
    import cmo_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    cmo_edge_if.flags edge_io
);
    typedef struct packed {
        logic prevOut;
        logic rise;
        logic fall;
    } cmo_flag_state_t;

    cmo_flag_state_t state_r;
    cmo_flag_state_t state_nxt;
    logic riseSeen;
    logic fallSeen;

    always_comb begin
        riseSeen = edge_io.compOut & ~state_r.prevOut;
        fallSeen = ~edge_io.compOut & state_r.prevOut;
        state_nxt = state_r;
        state_nxt.prevOut = edge_io.compOut;
        state_nxt.rise = riseSeen | (state_r.rise & ~edge_io.riseClear); // [R6]
        state_nxt.fall = fallSeen | (state_r.fall & ~edge_io.fallClear); // [R7]
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            state_r <= '0;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign edge_io.riseFlag = state_r.rise;
    assign edge_io.fallFlag = state_r.fall;

    property p_rise_set;
        @(posedge core_clk) disable iff (!rst_n)
        riseSeen |=> edge_io.riseFlag;
    endproperty
    a_rise_set: assert property (p_rise_set) else $error("rise flag not set"); // [R6]

    property p_rise_hold;
        @(posedge core_clk) disable iff (!rst_n)
        (edge_io.riseFlag && !edge_io.riseClear) |=> edge_io.riseFlag;
    endproperty
    a_rise_hold: assert property (p_rise_hold) else $error("rise flag lost"); // [R6]

    property p_fall_set;
        @(posedge core_clk) disable iff (!rst_n)
        fallSeen |=> edge_io.fallFlag;
    endproperty
    a_fall_set: assert property (p_fall_set) else $error("fall flag not set"); // [R7]

    property p_fall_hold;
        @(posedge core_clk) disable iff (!rst_n)
        (edge_io.fallFlag && !edge_io.fallClear) |=> edge_io.fallFlag;
    endproperty
    a_fall_hold: assert property (p_fall_hold) else $error("fall flag lost"); // [R7]

    property p_flag_cause;
        @(posedge core_clk) disable iff (!rst_n)
        $rose(edge_io.riseFlag) |-> $past(edge_io.compOut) && !$past(state_r.prevOut);
    endproperty
    a_flag_cause: assert property (p_flag_cause) else $error("rise flag without edge"); // [R6]
endmodule
`default_nettype wire

//--- design/cmo_mode_regs.sv
// Purpose: Comparator one mode and interrupt-enable register with interrupt request
// Assumes: Single-cycle byte register writes and reads at the register address
// Notes: Read data is registered and appears one cycle after the read strobe
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// R1: Bit 7 is reserved, always reads one, and software must write one there.
// R2: Bits 6, 3 and 2 read zero and ignore writes.
// R3: Bit 5 enables the rising-edge interrupt and masks it when zero.
// R4: Bit 4 enables the falling-edge interrupt and masks it when zero.
// R5: Bits 1:0 pick the speed and power mode from fastest 00 to slowest 11.
// R6: The rising-edge flag sets on each rising output edge and only software or reset clears it.
// R7: The falling-edge flag sets on each falling output edge and only software or reset clears it.
// R8: The interrupt request goes high one cycle after an edge flag and its enable are both set.
module cmo_mode_regs
    import cmo_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [7:0] regAddr,
    input wire logic regWrEn,
    input wire logic regRdEn,
    input wire logic [7:0] regWrData,
    output logic [7:0] regRdData,
    input wire logic compOut,
    input wire logic riseFlagClear,
    input wire logic fallFlagClear,
    output logic rise_event_flag,
    output logic fall_event_flag,
    output logic [1:0] speed_power_select,
    output logic compIrq
);
    typedef struct packed {
        logic riseIrqEnable;
        logic fallIrqEnable;
        logic [1:0] speedSel;
        logic [7:0] rdData;
        logic irq;
    } cmo_reg_state_t;

    cmo_reg_state_t state_r;
    cmo_reg_state_t state_nxt;
    cmo_edge_if edgeBus ();
    logic hit;
    logic [7:0] regView;
    logic irqNow;

    assign edgeBus.compOut = compOut;
    assign edgeBus.riseClear = riseFlagClear;
    assign edgeBus.fallClear = fallFlagClear;

    cmo_edge_flags u_flags (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .edge_io(edgeBus)
    );

    always_comb begin
        hit = (regAddr == CMO_MODE_ADDR);
        regView = '0; // [R2]
        regView[CMO_RSVD_BIT] = CMO_RSVD_VALUE; // [R1]
        regView[CMO_RISE_EN_BIT] = state_r.riseIrqEnable;
        regView[CMO_FALL_EN_BIT] = state_r.fallIrqEnable;
        regView[CMO_SPEED_LSB +: 2] = state_r.speedSel;
        irqNow = (edgeBus.riseFlag & state_r.riseIrqEnable)
            | (edgeBus.fallFlag & state_r.fallIrqEnable); // [R8]
        state_nxt = state_r;
        state_nxt.irq = irqNow;
        if (regWrEn && hit) begin
            state_nxt.riseIrqEnable = regWrData[CMO_RISE_EN_BIT]; // [R3]
            state_nxt.fallIrqEnable = regWrData[CMO_FALL_EN_BIT]; // [R4]
            state_nxt.speedSel = regWrData[CMO_SPEED_LSB +: 2]; // [R5]
        end
        if (regRdEn) begin
            state_nxt.rdData = hit ? regView : 8'h00;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            state_r.riseIrqEnable <= CMO_MODE_RESET[CMO_RISE_EN_BIT];
            state_r.fallIrqEnable <= CMO_MODE_RESET[CMO_FALL_EN_BIT];
            state_r.speedSel <= CMO_SPEED_RESET;
            state_r.rdData <= 8'h00;
            state_r.irq <= 1'b0;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign regRdData = state_r.rdData;
    assign rise_event_flag = edgeBus.riseFlag;
    assign fall_event_flag = edgeBus.fallFlag;
    assign speed_power_select = state_r.speedSel;
    assign compIrq = state_r.irq;

    property p_rsvd_read;
        @(posedge core_clk) disable iff (!rst_n)
        (regRdEn && hit) |=> regRdData[CMO_RSVD_BIT] == 1'b1;
    endproperty
    a_rsvd_read: assert property (p_rsvd_read) else $error("reserved bit not one"); // [R1]

    property p_unused_zero;
        @(posedge core_clk) disable iff (!rst_n)
        (regRdEn && hit) |=> (regRdData[6] == 1'b0) && (regRdData[3:2] == 2'b00);
    endproperty
    a_unused_zero: assert property (p_unused_zero) else $error("unused bits not zero"); // [R2]

    property p_rise_en_write;
        @(posedge core_clk) disable iff (!rst_n)
        (regWrEn && hit) |=> state_r.riseIrqEnable == $past(regWrData[5]);
    endproperty
    a_rise_en_write: assert property (p_rise_en_write) else $error("rise enable not written"); // [R3]

    property p_fall_en_write;
        @(posedge core_clk) disable iff (!rst_n)
        (regWrEn && hit) |=> state_r.fallIrqEnable == $past(regWrData[4]);
    endproperty
    a_fall_en_write: assert property (p_fall_en_write) else $error("fall enable not written"); // [R4]

    property p_speed_write;
        @(posedge core_clk) disable iff (!rst_n)
        (regWrEn && hit) |=> speed_power_select == $past(regWrData[1:0]);
    endproperty
    a_speed_write: assert property (p_speed_write) else $error("speed select wrong"); // [R5]

    property p_irq_masked;
        @(posedge core_clk) disable iff (!rst_n)
        (!state_r.riseIrqEnable && !state_r.fallIrqEnable) |=> !compIrq;
    endproperty
    a_irq_masked: assert property (p_irq_masked) else $error("masked irq raised"); // [R3] [R4]

    property p_irq_rise;
        @(posedge core_clk) disable iff (!rst_n)
        (rise_event_flag && state_r.riseIrqEnable) |=> compIrq;
    endproperty
    a_irq_rise: assert property (p_irq_rise) else $error("rise irq missing"); // [R8]

    property p_irq_fall;
        @(posedge core_clk) disable iff (!rst_n)
        (fall_event_flag && state_r.fallIrqEnable) |=> compIrq;
    endproperty
    a_irq_fall: assert property (p_irq_fall) else $error("fall irq missing"); // [R8]

    // Field hold, read-back, interrupt mask and interrupt source checks
    property p_rise_en_hold;
        @(posedge core_clk) disable iff (!rst_n)
        !(regWrEn && hit) |=> $stable(state_r.riseIrqEnable);
    endproperty
    a_rise_en_hold: assert property (p_rise_en_hold) else $error("rise enable changed"); // [R3]

    property p_fall_en_hold;
        @(posedge core_clk) disable iff (!rst_n)
        !(regWrEn && hit) |=> $stable(state_r.fallIrqEnable);
    endproperty
    a_fall_en_hold: assert property (p_fall_en_hold) else $error("fall enable changed"); // [R4]

    property p_speed_hold;
        @(posedge core_clk) disable iff (!rst_n)
        !(regWrEn && hit) |=> $stable(speed_power_select);
    endproperty
    a_speed_hold: assert property (p_speed_hold) else $error("speed select changed"); // [R5]

    property p_rise_en_read;
        @(posedge core_clk) disable iff (!rst_n)
        (regRdEn && hit) |=> regRdData[CMO_RISE_EN_BIT] == $past(state_r.riseIrqEnable);
    endproperty
    a_rise_en_read: assert property (p_rise_en_read) else $error("rise enable misread"); // [R3]

    property p_fall_en_read;
        @(posedge core_clk) disable iff (!rst_n)
        (regRdEn && hit) |=> regRdData[CMO_FALL_EN_BIT] == $past(state_r.fallIrqEnable);
    endproperty
    a_fall_en_read: assert property (p_fall_en_read) else $error("fall enable misread"); // [R4]

    property p_speed_read;
        @(posedge core_clk) disable iff (!rst_n)
        (regRdEn && hit) |=> regRdData[CMO_SPEED_LSB +: 2] == $past(speed_power_select);
    endproperty
    a_speed_read: assert property (p_speed_read) else $error("speed select misread"); // [R5]

    property p_irq_rise_masked;
        @(posedge core_clk) disable iff (!rst_n)
        (!state_r.riseIrqEnable && !(fall_event_flag && state_r.fallIrqEnable)) |=> !compIrq;
    endproperty
    a_irq_rise_masked: assert property (p_irq_rise_masked) else $error("rise not masked"); // [R3]

    property p_irq_fall_masked;
        @(posedge core_clk) disable iff (!rst_n)
        (!state_r.fallIrqEnable && !(rise_event_flag && state_r.riseIrqEnable)) |=> !compIrq;
    endproperty
    a_irq_fall_masked: assert property (p_irq_fall_masked) else $error("fall not masked"); // [R4]

    property p_irq_source;
        @(posedge core_clk) disable iff (!rst_n)
        compIrq |-> $past(rise_event_flag && state_r.riseIrqEnable)
            || $past(fall_event_flag && state_r.fallIrqEnable);
    endproperty
    a_irq_source: assert property (p_irq_source) else $error("irq without source"); // [R8]

    // Reset value checks
    property p_speed_reset;
        @(posedge core_clk)
        !rst_n |=> speed_power_select == CMO_SPEED_RESET;
    endproperty
    a_speed_reset: assert property (p_speed_reset) else $error("speed reset wrong"); // [R5]

    property p_irq_reset;
        @(posedge core_clk)
        !rst_n |=> !compIrq;
    endproperty
    a_irq_reset: assert property (p_irq_reset) else $error("irq high after reset"); // [R8]

    property p_view_reset;
        @(posedge core_clk)
        !rst_n |=> regView == CMO_MODE_RESET;
    endproperty
    a_view_reset: assert property (p_view_reset) else $error("reset view wrong"); // [R1]

    c_rise_irq: cover property (@(posedge core_clk) disable iff (!rst_n) $rose(compIrq));
    c_fall_irq: cover property (@(posedge core_clk) disable iff (!rst_n)
        fall_event_flag && state_r.fallIrqEnable && compIrq);
    c_set_over_clear: cover property (@(posedge core_clk) disable iff (!rst_n)
        riseFlagClear && compOut && !$past(compOut));
    c_write_reg: cover property (@(posedge core_clk) disable iff (!rst_n) regWrEn && hit);
    c_slowest: cover property (@(posedge core_clk) disable iff (!rst_n)
        speed_power_select == CMO_SPEED_SLOWEST);
endmodule
`default_nettype wire

//--- sim/tb_comparator_one_mode_ctrl.sv
// Purpose: Self-checking bench for the comparator one mode register
// Assumes: Reset view 0x82, read data one cycle after the strobe
// Notes: Flag clears are driven as plain ports
`timescale 1ns/1ps
`default_nettype none
module tb_comparator_one_mode_ctrl import cmo_pkg::*; ();
    logic core_clk;
    logic rst_n;
    logic [7:0] regAddr;
    logic [7:0] regWrData;
    logic [7:0] regRdData;
    logic regWrEn;
    logic regRdEn;
    logic compOut;
    logic riseFlagClear;
    logic fallFlagClear;
    logic rise_event_flag;
    logic fall_event_flag;
    logic compIrq;
    logic [1:0] speed_power_select;
    int errTotal;
    int checkCount;

    cmo_mode_regs u_dut (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .regAddr(regAddr),
        .regWrEn(regWrEn),
        .regRdEn(regRdEn),
        .regWrData(regWrData),
        .regRdData(regRdData),
        .compOut(compOut),
        .riseFlagClear(riseFlagClear),
        .fallFlagClear(fallFlagClear),
        .rise_event_flag(rise_event_flag),
        .fall_event_flag(fall_event_flag),
        .speed_power_select(speed_power_select),
        .compIrq(compIrq)
    );

    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checkCount++;
        if (seen !== exp) begin
            errTotal++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        regAddr <= a;
        regWrData <= d;
        regWrEn <= 1'b1;
        @(posedge core_clk);
        regWrEn <= 1'b0;
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
        @(posedge core_clk);
        regAddr <= a;
        regRdEn <= 1'b1;
        @(posedge core_clk);
        regRdEn <= 1'b0;
        #1;
        chk(regRdData, e);
    endtask

    // Flags and request packed as rise, fall, irq
    task automatic flagchk(input logic [2:0] e);
        chk({5'h00, rise_event_flag, fall_event_flag, compIrq}, {5'h00, e});
    endtask

    task automatic test_reset();
        rdchk(CMO_MODE_ADDR, 8'h82);
        chk({6'h00, speed_power_select}, 8'h02);
        flagchk(3'b000);
        $display("test reset done");
    endtask

    task automatic test_loose_bits();
        wr(CMO_MODE_ADDR, 8'hff);
        rdchk(CMO_MODE_ADDR, 8'hb3);
        wr(CMO_MODE_ADDR, 8'hcc);
        rdchk(CMO_MODE_ADDR, 8'h80);
        wr(8'h9d, 8'hb3);
        rdchk(CMO_MODE_ADDR, 8'h80);
        rdchk(8'h9d, 8'h00);
        $display("test loose bits done");
    endtask

    task automatic test_speed();
        for (int c = 0; c < 4; c++) begin
            wr(CMO_MODE_ADDR, 8'h80 | 8'(c));
            tick(1);
            chk({6'h00, speed_power_select}, 8'(c));
            rdchk(CMO_MODE_ADDR, 8'h80 | 8'(c));
        end
        $display("test speed done");
    endtask

    task automatic test_edges();
        wr(CMO_MODE_ADDR, 8'ha0);
        @(posedge core_clk);
        compOut <= 1'b1;
        tick(3);
        flagchk(3'b101);
        @(posedge core_clk);
        compOut <= 1'b0;
        tick(3);
        flagchk(3'b111);
        @(posedge core_clk);
        riseFlagClear <= 1'b1;
        @(posedge core_clk);
        riseFlagClear <= 1'b0;
        tick(2);
        flagchk(3'b010);
        wr(CMO_MODE_ADDR, 8'h90);
        tick(2);
        flagchk(3'b011);
        @(posedge core_clk);
        fallFlagClear <= 1'b1;
        @(posedge core_clk);
        fallFlagClear <= 1'b0;
        tick(2);
        flagchk(3'b000);
        $display("test edges done");
    endtask

    task automatic test_collide();
        wr(CMO_MODE_ADDR, 8'h80);
        @(posedge core_clk);
        compOut <= 1'b1;
        riseFlagClear <= 1'b1;
        @(posedge core_clk);
        riseFlagClear <= 1'b0;
        tick(2);
        flagchk(3'b100);
        @(posedge core_clk);
        compOut <= 1'b0;
        riseFlagClear <= 1'b1;
        fallFlagClear <= 1'b1;
        @(posedge core_clk);
        riseFlagClear <= 1'b0;
        fallFlagClear <= 1'b0;
        tick(2);
        flagchk(3'b010);
        $display("test collide done");
    endtask

    task automatic test_midreset();
        wr(CMO_MODE_ADDR, 8'hb1);
        tick(2);
        flagchk(3'b011);
        @(posedge core_clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge core_clk);
        rst_n <= 1'b1;
        tick(1);
        flagchk(3'b000);
        chk({6'h00, speed_power_select}, 8'h02);
        @(posedge core_clk);
        regAddr <= CMO_MODE_ADDR;
        regWrData <= 8'hb0;
        regWrEn <= 1'b1;
        regRdEn <= 1'b1;
        @(posedge core_clk);
        regWrEn <= 1'b0;
        regRdEn <= 1'b0;
        #1;
        chk(regRdData, 8'h82);
        rdchk(CMO_MODE_ADDR, 8'hb0);
        $display("test midreset done");
    endtask

    task automatic conclude();
        $display("checks=%0d mismatches=%0d", checkCount, errTotal);
        if (errTotal == 0 && checkCount > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    initial begin
        #20000;
        errTotal++;
        conclude();
    end

    initial begin
        errTotal = 0;
        checkCount = 0;
        rst_n = 1'b0;
        regAddr = 8'h00;
        regWrData = 8'h00;
        regWrEn = 1'b0;
        regRdEn = 1'b0;
        compOut = 1'b0;
        riseFlagClear = 1'b0;
        fallFlagClear = 1'b0;
        repeat (4) @(posedge core_clk);
        rst_n <= 1'b1;
        test_reset();
        test_loose_bits();
        test_speed();
        test_edges();
        test_collide();
        test_midreset();
        conclude();
    end
endmodule
`default_nettype wire
